// ---- logic/aycs_pkg.sv ----
// Constants shared by the adaptive luma/chroma separator and its output FIFO.
// Assumes one master clock at 200 MHz and 8-bit offset-binary video samples.
package aycs_pkg;
	localparam int       SAMPLE_W       = 8;
	localparam int       LINE_LEN       = 910;
	localparam int       PTR_W          = 10;
	localparam int       BYPASS_EXTRA   = 18;
	localparam int       BYP_PIPE       = BYPASS_EXTRA - 1;
	localparam int       MONITOR_DELAY  = 4;
	localparam int       CENTER_DELAY   = 3;
	localparam int       FIFO_DEPTH     = 8;
	localparam int       FIFO_W         = 2 * SAMPLE_W;
	localparam int       CNT_W          = 16;
	localparam int       PLL_MULT_SHIFT = 3;
	localparam logic [8:0]  CORR_THRESH = 9'h010;
	localparam logic [7:0]  CHROMA_ZERO = 8'h80;
	localparam logic [7:0]  SAMPLE_RST  = 8'h00;
	localparam logic [15:0] CNT_RST     = 16'h0000;
endpackage

// ---- logic/aycs_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module aycs_fifo
	import aycs_pkg::*;
#(
	parameter int WIDTH = FIFO_W,
	parameter int DEPTH = FIFO_DEPTH
)
(
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] i_wdata,
	input  wire logic             i_wvalid,
	output logic                  o_wready,
	output logic      [WIDTH-1:0] o_rdata,
	output logic                  o_rvalid,
	input  wire logic             i_rready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0]      wr_reg;
	logic [AW:0]      rd_reg;
	wire              push = i_wvalid && o_wready;
	wire              pop  = o_rvalid && i_rready;
	wire  [AW:0]      used = wr_reg - rd_reg;

	assign o_wready = (used != (AW+1)'(DEPTH));
	assign o_rvalid = (used != '0);
	assign o_rdata  = mem_reg[rd_reg[AW-1:0]];

	always_ff @(posedge clk)
	begin
		if (push)
			mem_reg[wr_reg[AW-1:0]] <= i_wdata;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wr_reg <= '0;
			rd_reg <= '0;
		end
		else
		begin
			wr_reg <= wr_reg + (AW+1)'(push);
			rd_reg <= rd_reg + (AW+1)'(pop);
		end
	end

	property p_fifo_bound;
		@(posedge clk) disable iff (!rst_n) used <= (AW+1)'(DEPTH);
	endproperty
	a_fifo_bound: assert property (p_fifo_bound) else $error("fifo occupancy above depth");
endmodule

// ---- logic/aycs_top.sv ----
// Adaptive luma/chroma separator: source select, two line stores, comb/bandpass
// separation, aperture compensation, bypass and monitor paths, output FIFO, 4x clock.
// Assumes all inputs synchronous to I_MCLK and the mode selects held static.
`timescale 1ns/1ps
module aycs_top
	import aycs_pkg::*;
(
	input  wire logic                I_MCLK,
	input  wire logic                I_RST_N,
	input  wire logic                I_INPUT_SOURCE_SELECT,
	input  wire logic                I_LUMA_BYPASS_SELECT,
	input  wire logic                I_CONVERTER_MONITOR_SELECT,
	input  wire logic                I_APERTURE_SELECT,
	input  wire logic                I_BANDPASS_ONLY_SELECT,
	input  wire logic                I_LUMA_OUTPUT_DISABLE,
	input  wire logic                I_CHROMA_OUTPUT_DISABLE,
	input  wire logic [SAMPLE_W-1:0] I_COMPOSITE_IN,
	input  wire logic [SAMPLE_W-1:0] I_CONVERTER_IN,
	input  wire logic                I_SAMPLE_VALID,
	output logic                     O_SAMPLE_READY,
	input  wire logic                I_SUBCARRIER_REF_IN,
	output logic [SAMPLE_W-1:0]      O_LUMA_OUT,
	output logic                     O_LUMA_OE,
	output logic [SAMPLE_W-1:0]      O_CHROMA_OUT,
	output logic                     O_CHROMA_OE,
	output logic                     O_OUT_VALID,
	input  wire logic                I_OUT_READY,
	output logic                     O_PLL_CLOCK_OUT
);
	// The whole pipeline moves only when a sample is offered and the FIFO has room,
	// so back-pressure from the output stalls the line stores rather than dropping data.
	logic                adv;
	logic                fifo_wready;
	logic [SAMPLE_W-1:0] src_sel;
	logic [SAMPLE_W-1:0] s0_reg;
	logic [SAMPLE_W-1:0] line_q [3];
	logic [PTR_W-1:0]    ptr_reg;
	logic [SAMPLE_W-1:0] h_reg   [5];
	logic [SAMPLE_W-1:0] a0_reg  [CENTER_DELAY];
	logic [SAMPLE_W-1:0] a2_reg  [CENTER_DELAY];
	logic [SAMPLE_W-1:0] byp_reg [BYP_PIPE];
	logic [SAMPLE_W-1:0] mon_reg [MONITOR_DELAY];
	logic [SAMPLE_W-1:0] ya_reg  [3];
	logic [SAMPLE_W-1:0] cd_reg  [2];

	assign adv            = I_SAMPLE_VALID && fifo_wready;
	assign O_SAMPLE_READY = fifo_wready;
	assign src_sel        = I_INPUT_SOURCE_SELECT ? I_COMPOSITE_IN : I_CONVERTER_IN;

	always_ff @(posedge I_MCLK)
	begin
		if (!I_RST_N)
			s0_reg <= SAMPLE_RST;
		else if (adv)
			s0_reg <= src_sel;
	end

	assign line_q[0] = s0_reg;

	always_ff @(posedge I_MCLK)
	begin
		if (!I_RST_N)
			ptr_reg <= '0;
		else if (adv)
			ptr_reg <= (ptr_reg == PTR_W'(LINE_LEN - 2)) ? '0 : ptr_reg + 1'b1;
	end

	// Read-before-write circular stores. The registered read adds one sample, so each
	// store holds one sample fewer than a line and the taps land exactly a line apart.
	// Contents are not cleared, so the first two lines after reset carry stale data.
	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_line
			logic [SAMPLE_W-1:0] mem_reg [LINE_LEN-1];
			logic [SAMPLE_W-1:0] q_reg;
			always_ff @(posedge I_MCLK)
			begin
				if (adv)
				begin
					mem_reg[ptr_reg] <= line_q[g];
					q_reg            <= mem_reg[ptr_reg];
				end
			end
			assign line_q[g+1] = q_reg;
		end
	endgenerate

	// Delay lines shifted on every advance and held while stalled: horizontal taps, aligned vertical taps,
	// bypass tail, converter monitor and the luma/chroma alignment stages.
	logic [SAMPLE_W-1:0] y_pre;
	logic [SAMPLE_W-1:0] c_pre;

	always_ff @(posedge I_MCLK)
	begin
		if (adv)
		begin
			h_reg   <= {line_q[1], h_reg[0:3]};
			a0_reg  <= {line_q[0], a0_reg[0:CENTER_DELAY-2]};
			a2_reg  <= {line_q[2], a2_reg[0:CENTER_DELAY-2]};
			byp_reg <= {line_q[1], byp_reg[0:BYP_PIPE-2]};
			mon_reg <= {I_CONVERTER_IN, mon_reg[0:MONITOR_DELAY-2]};
			ya_reg  <= {y_pre, ya_reg[0:1]};
			cd_reg  <= {c_pre, cd_reg[0]};
		end
	end

	// Signed chroma estimates on the centre line; both are a full second difference, quartered
	// after the choice, so they share one scale and can be swapped sample by sample.
	wire signed [10:0] ctr  = 11'(h_reg[2]);
	wire signed [10:0] comb = (ctr <<< 1) - 11'(a0_reg[CENTER_DELAY-1]) - 11'(a2_reg[CENTER_DELAY-1]);
	wire signed [10:0] bandpass_only_select  = (ctr <<< 1) - 11'(h_reg[0]) - 11'(h_reg[4]);
	wire signed [10:0] vdif = 11'(a0_reg[CENTER_DELAY-1]) - 11'(a2_reg[CENTER_DELAY-1]);
	wire        [8:0]  vmag = vdif[10] ? 9'(-vdif) : 9'(vdif);
	wire               use_comb = !I_BANDPASS_ONLY_SELECT && (vmag < CORR_THRESH);
	wire signed [10:0] chroma_s = (use_comb ? comb : bandpass_only_select) >>> 2;
	wire signed [10:0] luma_s   = ctr - chroma_s;

	assign c_pre = 8'(chroma_s) + CHROMA_ZERO;
	assign y_pre = luma_s[10] ? 8'h00 : (luma_s > 11'sh0FF) ? 8'hFF : luma_s[7:0];

	// Horizontal aperture: add a quarter of the luma second difference, clipped.
	wire signed [10:0] yc   = 11'(ya_reg[1]);
	wire signed [10:0] ysd  = (yc <<< 1) - 11'(ya_reg[0]) - 11'(ya_reg[2]);
	wire signed [10:0] peak = ysd >>> 2;
	wire signed [10:0] ysum = yc + peak;
	wire        [7:0]  y_ap = ysum[10] ? 8'h00 : (ysum > 11'sh0FF) ? 8'hFF : ysum[7:0];

	wire [SAMPLE_W-1:0] y_sel = I_CONVERTER_MONITOR_SELECT ? mon_reg[MONITOR_DELAY-1] :
		I_LUMA_BYPASS_SELECT ? byp_reg[BYP_PIPE-1] :
		I_APERTURE_SELECT ? y_ap : ya_reg[1];
	wire [SAMPLE_W-1:0] c_sel = cd_reg[1];

	aycs_fifo #(
		.WIDTH (FIFO_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk      (I_MCLK),
		.rst_n    (I_RST_N),
		.i_wdata  ({y_sel, c_sel}),
		.i_wvalid (I_SAMPLE_VALID),
		.o_wready (fifo_wready),
		.o_rdata  ({O_LUMA_OUT, O_CHROMA_OUT}),
		.o_rvalid (O_OUT_VALID),
		.i_rready (I_OUT_READY)
	);

	assign O_LUMA_OE   = !I_LUMA_OUTPUT_DISABLE;
	assign O_CHROMA_OE = !I_CHROMA_OUTPUT_DISABLE;

	// Digital 4x clock: measure the reference period in master clocks, then toggle
	// every eighth of it. Jitter is one master clock; good enough for a 14 MHz output.
	logic             ref_s1_reg;
	logic             ref_s2_reg;
	logic             ref_d_reg;
	logic [CNT_W-1:0] per_cnt_reg;
	logic [CNT_W-1:0] half_reg;
	logic [CNT_W-1:0] div_reg;
	logic             pll_reg;
	wire              ref_rise = ref_s2_reg && !ref_d_reg;
	wire              div_hit  = (half_reg != CNT_RST) && (div_reg >= half_reg - 1'b1);

	always_ff @(posedge I_MCLK)
	begin
		if (!I_RST_N)
		begin
			ref_s1_reg  <= 1'b0;
			ref_s2_reg  <= 1'b0;
			ref_d_reg   <= 1'b0;
			per_cnt_reg <= CNT_RST;
			half_reg    <= CNT_RST;
			div_reg     <= CNT_RST;
			pll_reg     <= 1'b0;
		end
		else
		begin
			ref_s1_reg  <= I_SUBCARRIER_REF_IN;
			ref_s2_reg  <= ref_s1_reg;
			ref_d_reg   <= ref_s2_reg;
			per_cnt_reg <= ref_rise ? 16'h0001 : per_cnt_reg + 1'b1;
			if (ref_rise)
				half_reg <= per_cnt_reg >> PLL_MULT_SHIFT;
			div_reg <= div_hit ? CNT_RST : div_reg + 1'b1;
			if (div_hit)
				pll_reg <= !pll_reg;
		end
	end

	assign O_PLL_CLOCK_OUT = pll_reg;

	property p_src;
		@(posedge I_MCLK) disable iff (!I_RST_N)
			adv |=> s0_reg == $past(I_INPUT_SOURCE_SELECT ? I_COMPOSITE_IN : I_CONVERTER_IN);
	endproperty
	a_src: assert property (p_src) else $error("selected source not captured");

	property p_bypass;
		@(posedge I_MCLK) disable iff (!I_RST_N)
			adv && I_LUMA_BYPASS_SELECT && !I_CONVERTER_MONITOR_SELECT |-> y_sel == byp_reg[BYP_PIPE-1];
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass luma not from line tail");

	property p_sep;
		@(posedge I_MCLK) disable iff (!I_RST_N)
			!I_LUMA_BYPASS_SELECT && !I_CONVERTER_MONITOR_SELECT && !I_APERTURE_SELECT |-> y_sel == ya_reg[1];
	endproperty
	a_sep: assert property (p_sep) else $error("separated luma not selected");

	property p_monitor;
		@(posedge I_MCLK) disable iff (!I_RST_N)
			adv ##1 adv ##1 adv ##1 adv ##1 (adv && I_CONVERTER_MONITOR_SELECT) |->
				y_sel == $past(I_CONVERTER_IN, 4);
	endproperty
	a_monitor: assert property (p_monitor) else $error("monitor latency wrong");

	property p_aperture;
		@(posedge I_MCLK) disable iff (!I_RST_N)
			I_APERTURE_SELECT && !I_LUMA_BYPASS_SELECT && !I_CONVERTER_MONITOR_SELECT && ya_reg[0] == ya_reg[1]
				&& ya_reg[1] == ya_reg[2] |-> y_sel == ya_reg[1];
	endproperty
	a_aperture: assert property (p_aperture) else $error("aperture alters flat luma");

	property p_bandpass;
		@(posedge I_MCLK) disable iff (!I_RST_N)
			I_BANDPASS_ONLY_SELECT |-> chroma_s == (bandpass_only_select >>> 2);
	endproperty
	a_bandpass: assert property (p_bandpass) else $error("bandpass-only not obeyed");

	property p_oe;
		@(posedge I_MCLK) O_LUMA_OE != I_LUMA_OUTPUT_DISABLE && O_CHROMA_OE != I_CHROMA_OUTPUT_DISABLE;
	endproperty
	a_oe: assert property (p_oe) else $error("output enable mismatch");

	property p_line;
		@(posedge I_MCLK) disable iff (!I_RST_N)
			adv |=> ptr_reg == (($past(ptr_reg) == PTR_W'(LINE_LEN - 2)) ? '0 : $past(ptr_reg) + 1'b1);
	endproperty
	a_line: assert property (p_line) else $error("line pointer misstepped");

	property p_comb;
		@(posedge I_MCLK) disable iff (!I_RST_N)
			!I_BANDPASS_ONLY_SELECT && vmag < CORR_THRESH |-> chroma_s == (comb >>> 2) && luma_s == ctr - chroma_s;
	endproperty
	a_comb: assert property (p_comb) else $error("correlated sample not combed");

	property p_pll;
		@(posedge I_MCLK) disable iff (!I_RST_N)
			$changed(pll_reg) |-> $past(half_reg) != CNT_RST;
	endproperty
	a_pll: assert property (p_pll) else $error("clock toggles before period known");
endmodule

// ---- tb/aycs_sink_model.sv ----
// Downstream video sink that takes luma/chroma pairs and stalls at random.
// Assumes the design's output valid/ready handshake on the master clock.
`timescale 1ns/1ps
module aycs_sink_model
(
	input  wire logic       i_clk,
	input  wire logic       i_valid,
	input  wire logic [7:0] i_luma,
	input  wire logic [7:0] i_chroma,
	input  wire logic [6:0] i_stall_pct,
	output logic            o_ready
);
	logic [15:0] words [$];

	initial
	begin
		o_ready = 1'b0;
	end

	// Ready moves just after an edge; a word is logged just before the next edge if valid and ready are both high.
	always
	begin
		@(posedge i_clk);
		#1;
		o_ready = (($urandom % 100) >= i_stall_pct);
		#3;
		if (i_valid && o_ready)
			words.push_back({i_luma, i_chroma});
	end
endmodule

// ---- tb/adaptive_yc_separator_tb.sv ----
// Self-checking bench for the separator: modes, latencies, output enables, FIFO and 4x clock.
// Assumes the sink model is compiled first; the sample source is driven from here.
`timescale 1ns/1ps
module adaptive_yc_separator_tb;
	import aycs_pkg::*;

	logic                mclk = 1'b0, rst_n = 1'b0, in_valid = 1'b0, ref_in = 1'b0;
	logic                src_sel = 1'b0, byp = 1'b0, mon = 1'b0, ap = 1'b0, bandpass_only_select = 1'b0;
	logic                y_dis = 1'b0, c_dis = 1'b0, pll_prev;
	logic [SAMPLE_W-1:0] comp = 8'h00, conv = 8'h00, luma, chroma;
	logic                smp_ready, luma_oe, chroma_oe, out_valid, out_ready, pll_out;
	logic [6:0]          stall = 7'h19;
	logic [SAMPLE_W-1:0] comp_q [$], conv_q [$], line_pat [LINE_LEN];
	int                  mismatches = 0, checks = 0, cnt, prev_t, last_t;

	always #2.5 mclk = ~mclk;

	// Subcarrier reference with a period of 64 master clocks.
	always
	begin
		repeat (32) @(posedge mclk);
		#1;
		ref_in = ~ref_in;
	end

	aycs_top dut (.I_MCLK(mclk), .I_RST_N(rst_n), .I_INPUT_SOURCE_SELECT(src_sel),
		.I_LUMA_BYPASS_SELECT(byp), .I_CONVERTER_MONITOR_SELECT(mon), .I_APERTURE_SELECT(ap),
		.I_BANDPASS_ONLY_SELECT(bandpass_only_select), .I_LUMA_OUTPUT_DISABLE(y_dis), .I_CHROMA_OUTPUT_DISABLE(c_dis),
		.I_COMPOSITE_IN(comp), .I_CONVERTER_IN(conv), .I_SAMPLE_VALID(in_valid),
		.O_SAMPLE_READY(smp_ready), .I_SUBCARRIER_REF_IN(ref_in), .O_LUMA_OUT(luma),
		.O_LUMA_OE(luma_oe), .O_CHROMA_OUT(chroma), .O_CHROMA_OE(chroma_oe),
		.O_OUT_VALID(out_valid), .I_OUT_READY(out_ready), .O_PLL_CLOCK_OUT(pll_out));

	// No test pins are brought out, so none can leave their low level.
	aycs_sink_model sink (.i_clk(mclk), .i_valid(out_valid), .i_luma(luma), .i_chroma(chroma),
		.i_stall_pct(stall), .o_ready(out_ready));

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic logic [7:0] src_at(input int n);
		return src_sel ? comp_q[n] : conv_q[n];
	endfunction

	// Fixed bandpass chroma: a quarter of the second difference two samples either side.
	function automatic logic [7:0] bp_chroma(input int c);
		int d;
		d = (2 * int'(src_at(c)) - int'(src_at(c - 2)) - int'(src_at(c + 2))) >>> 2;
		return 8'(d) + CHROMA_ZERO;
	endfunction

	task automatic do_reset();
		rst_n = 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		check8("reset out valid", 8'h00, {7'h00, out_valid});
		check8("reset sample ready", 8'h01, {7'h00, smp_ready});
		check8("reset clock out", 8'h00, {7'h00, pll_out});
		rst_n = 1'b1;
	endtask

	task automatic next_sample(input bit patt);
		logic [SAMPLE_W-1:0] p;
		p = patt ? line_pat[comp_q.size() % LINE_LEN] : SAMPLE_W'($urandom);
		in_valid = ($urandom % 4) != 0;
		comp = src_sel ? p : SAMPLE_W'($urandom);
		conv = src_sel ? SAMPLE_W'($urandom) : p;
	endtask

	// Modes are set before reset and held for the whole run.
	task automatic run(input logic [4:0] modes, input int n, input bit patt);
		logic acc;
		int   guard;
		{src_sel, byp, mon, ap, bandpass_only_select} = modes;
		comp_q.delete();
		conv_q.delete();
		do_reset();
		// Cleared only after reset: the sink may still log a word left over from the last run.
		sink.words.delete();
		next_sample(patt);
		guard = 0;
		while (sink.words.size() < n)
		begin
			#3;
			acc = in_valid && smp_ready;
			@(posedge mclk);
			#1;
			if (acc)
			begin
				comp_q.push_back(comp);
				conv_q.push_back(conv);
			end
			if (acc || !in_valid)
				next_sample(patt);
			guard++;
			if (guard > 8 * n)
			begin
				check8("run words", 8'h01, 8'h00);
				tally_and_finish();
			end
		end
	endtask

	initial
	begin
		cnt = $urandom(32'hF1EDF660);
		foreach (line_pat[i])
			line_pat[i] = SAMPLE_W'($urandom);
		do_reset();
		for (int k = 0; k < 4; k++)
		begin
			{y_dis, c_dis} = k[1:0];
			#3;
			check8("luma oe", {7'h00, !y_dis}, {7'h00, luma_oe});
			check8("chroma oe", {7'h00, !c_dis}, {7'h00, chroma_oe});
			@(posedge mclk);
			#1;
		end
		// Sink held off: the ninth sample must be refused, then all eight drain, the last four checked in order.
		{src_sel, byp, mon, ap, bandpass_only_select, y_dis, c_dis} = 7'h50;
		stall = 7'h64;
		conv_q.delete();
		sink.words.delete();
		do_reset();
		in_valid = 1'b1;
		cnt = 0;
		repeat (12)
		begin
			conv = SAMPLE_W'($urandom);
			comp = ~conv;
			#3;
			if (smp_ready)
			begin
				cnt++;
				conv_q.push_back(conv);
			end
			@(posedge mclk);
			#1;
		end
		check8("fill count", 8'h08, 8'(cnt));
		check8("full ready", 8'h00, {7'h00, smp_ready});
		in_valid = 1'b0;
		stall = 7'h00;
		repeat (12) @(posedge mclk);
		#3;
		check8("drain count", 8'h08, 8'(sink.words.size()));
		check8("empty valid", 8'h00, {7'h00, out_valid});
		for (int n = 4; n < 8; n++)
			check8("monitor luma", conv_q[n-4], sink.words[n][15:8]);
		stall = 7'h19;
		run(5'b10100, 300, 0);
		for (int n = 4; n < 300; n++)
			check8("monitor luma", conv_q[n-4], sink.words[n][15:8]);
		for (int s = 0; s < 2; s++)
		begin
			run({s[0], 4'b1000}, 1100, 0);
			for (int n = LINE_LEN + BYPASS_EXTRA; n < 1100; n++)
				check8("bypass luma", src_at(n - LINE_LEN - BYPASS_EXTRA), sink.words[n][15:8]);
		end
		// Identical lines give perfect vertical correlation, so combing must cancel chroma.
		run(5'b10000, 2400, 1);
		for (int n = 2 * LINE_LEN + 20; n < 2400; n++)
		begin
			check8("comb luma", src_at(n - LINE_LEN - 6), sink.words[n][15:8]);
			check8("comb chroma", CHROMA_ZERO, sink.words[n][7:0]);
		end
		run(5'b10010, 2400, 1);
		cnt = 0;
		for (int n = 2 * LINE_LEN + 20; n < 2400; n++)
			cnt += (sink.words[n][15:8] !== src_at(n - LINE_LEN - 6));
		check8("aperture effect", 8'h01, {7'h00, cnt > 0});
		run(5'b00001, 2400, 1);
		cnt = 0;
		for (int n = 2 * LINE_LEN + 20; n < 2400; n++)
		begin
			cnt += (sink.words[n][7:0] !== CHROMA_ZERO);
			check8("bandpass chroma value", bp_chroma(n - LINE_LEN - 6), sink.words[n][7:0]);
		end
		check8("bandpass chroma", 8'h01, {7'h00, cnt > 0});
		prev_t = -1;
		last_t = -1;
		pll_prev = pll_out;
		for (int t = 0; t < 200; t++)
		begin
			@(posedge mclk);
			#3;
			if (pll_out !== pll_prev)
			begin
				prev_t = last_t;
				last_t = t;
			end
			pll_prev = pll_out;
		end
		check8("clock out half period", 8'h08, 8'(last_t - prev_t));
		tally_and_finish();
	end
endmodule
